// ---- core/pmics_defines.svh ----
// Register map, field layouts, reset values and frame layout of the interrupt bookkeeping block.
// Overview of operation
// - Reset-pin bits stay at default while the reset pin is low.
// - RTC power-on bits are released once the RTC supply is good.
// - Off-state bits return to default on the internal off-entry pulse.
// - Hardwired and sense bits have no reset source.
// - Mode-dependent bits load from mode pins at start, then stay host writable.
// - Live sense bits follow their input continuously, never latched.
// - Latched sense bits capture their input at startup and hold it.
// - Bits without a fixed default may power up at a version-dependent value.
// - Status bits are write-one-to-clear with default 0; bits 0, 1 flag conversions.
// - Flags 3, 6, 12, 16 are reset by the off-state signal.
// - Flags 5 and 7 are reset only by the RTC power-on reset.
// - Flags 19, 20, 21 are reset by the reset pin.
// - Each mask bit matches its flag, same reset source, default 1.
// - Reserved 15, 17, 18, 22, 23 read-only: 0 in status, 1 in mask.
// - Sense gives live levels matching the flags; unused and reserved read 0.
// - Sense bit 7 is charger enable; bits 8, 9 are the fault code.
// - Writing 1 clears a status bit; writing 0 leaves it.
// - Registers are 24 bits wide in a map numbered 0 to 63.
`ifndef PMICS_DEFINES_SVH
`define PMICS_DEFINES_SVH

`define PMICS_REG_W 24
`define PMICS_ADDR_W 6
`define PMICS_OFS_FLAGS 6'h00
`define PMICS_OFS_MASKS 6'h01
`define PMICS_OFS_SENSE 6'h02

`define PMICS_IMPL_BITS 24'h39_7FFF
`define PMICS_PIN_BITS 24'h38_6F17
`define PMICS_OFF_BITS 24'h01_1048
`define PMICS_RTC_BITS 24'h00_00A0
`define PMICS_SENSE_BITS 24'h19_7FF8
`define PMICS_FLAGS_RST 24'h00_0000
`define PMICS_MASKS_RST 24'hFF_FFFF
`define PMICS_ZERO 24'h00_0000

`define PMICS_FRAME_BITS 6'h20
`define PMICS_ADDR_DONE 6'h07
`define PMICS_DATA_START 6'h08
`define PMICS_RW_POS 31

`endif

// ---- core/pmics_irq_top.sv ----
// Interrupt group 0 register file: event flags, masks, live levels and the interrupt request.
`timescale 1ns/1ps
module pmics_irq_top #(
  parameter logic [23:0] SENSE_LATCH_BITS = 24'h00_0000,
  parameter logic [23:0] SENSE_POWERUP = 24'h00_0000,
  parameter logic [23:0] MASK_MODE_BITS = 24'h00_0000
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic system_reset_pin_n,
  input wire logic rtc_power_on_reset_n,
  input wire logic off_entry_reset_n,
  input wire logic start_begin_p,
  input wire pmics_pkg::pmics_word_t mode_defaults,
  input wire pmics_pkg::pmics_word_t src_event_lvl,
  input wire pmics_pkg::pmics_word_t src_sense_lvl,
  input wire logic spi_clk,
  input wire logic spi_cs_b,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  output logic irq_req
);
  import pmics_pkg::*;
  `include "pmics_defines.svh"

  pmics_reg_if reg_bus ();

  pmics_state_t cur_reg;
  pmics_state_t cur_next;
  pmics_word_t evt_rise;
  pmics_word_t force_bits;
  pmics_word_t w1c_bits;
  pmics_word_t sense_view;
  logic wr_flags;
  logic wr_masks;

  // Reads return a whole register; unmapped indices of the map read zero.
  function automatic pmics_word_t pmics_read(input pmics_addr_t addr, input pmics_word_t flags,
                                             input pmics_word_t masks, input pmics_word_t sense);
    case (addr)
      `PMICS_OFS_FLAGS: pmics_read = flags & `PMICS_IMPL_BITS;
      `PMICS_OFS_MASKS: pmics_read = masks | ~`PMICS_IMPL_BITS;
      `PMICS_OFS_SENSE: pmics_read = sense;
      default: pmics_read = `PMICS_ZERO;
    endcase
  endfunction

  pmics_spi_port u_port (
    .mclk(mclk),
    .rst_b(rst_b),
    .spi_clk(spi_clk),
    .spi_cs_b(spi_cs_b),
    .spi_mosi(spi_mosi),
    .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe),
    .bus(reg_bus.engine)
  );

  assign wr_flags = reg_bus.wr_p && reg_bus.addr == `PMICS_OFS_FLAGS;
  assign wr_masks = reg_bus.wr_p && reg_bus.addr == `PMICS_OFS_MASKS;
  assign evt_rise = cur_reg.evt_s1 & ~cur_reg.evt_s2 & `PMICS_IMPL_BITS;
  assign w1c_bits = wr_flags ? reg_bus.wdata : `PMICS_ZERO;

  // Each reset source forces only its own bit group; hardwired and sense bits have no source.
  always_comb begin
    force_bits = `PMICS_ZERO;
    if (!cur_reg.pin_s[1]) begin
      force_bits = force_bits | `PMICS_PIN_BITS;
    end
    if (!cur_reg.rtc_s[1]) begin
      force_bits = force_bits | `PMICS_RTC_BITS;
    end
    if (!off_entry_reset_n) begin
      force_bits = force_bits | `PMICS_OFF_BITS;
    end
  end

  // Latched bits hold the startup capture; all other sense bits are live.
  assign sense_view = ((cur_reg.sns_s1 & ~SENSE_LATCH_BITS) | (cur_reg.latched & SENSE_LATCH_BITS))
                      & `PMICS_SENSE_BITS;
  assign reg_bus.rdata = pmics_read(reg_bus.addr, cur_reg.flags, cur_reg.masks, sense_view);

  always_comb begin
    cur_next = cur_reg;
    cur_next.evt_s0 = src_event_lvl;
    cur_next.evt_s1 = cur_reg.evt_s0;
    cur_next.evt_s2 = cur_reg.evt_s1;
    cur_next.sns_s0 = src_sense_lvl;
    cur_next.sns_s1 = cur_reg.sns_s0;
    cur_next.pin_s = {cur_reg.pin_s[0], system_reset_pin_n};
    cur_next.rtc_s = {cur_reg.rtc_s[0], rtc_power_on_reset_n};
    // A new event in the same cycle as its clear wins, so no edge is lost.
    cur_next.flags = ((cur_reg.flags & ~w1c_bits) | evt_rise) & `PMICS_IMPL_BITS;
    if (wr_masks) begin
      cur_next.masks = reg_bus.wdata | ~`PMICS_IMPL_BITS;
    end
    if (start_begin_p) begin
      cur_next.masks = (cur_next.masks & ~MASK_MODE_BITS) | (mode_defaults & MASK_MODE_BITS);
      cur_next.latched = cur_reg.sns_s1 & SENSE_LATCH_BITS;
    end
    cur_next.flags = cur_next.flags & ~force_bits;
    cur_next.masks = cur_next.masks | force_bits;
    cur_next.irq = |(cur_reg.flags & ~cur_reg.masks & `PMICS_IMPL_BITS);
  end

  // Latched sense powers up at a version-dependent value given as a parameter.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cur_reg <= '{flags: `PMICS_FLAGS_RST, masks: `PMICS_MASKS_RST, latched: SENSE_POWERUP,
                   evt_s0: `PMICS_ZERO, evt_s1: `PMICS_ZERO, evt_s2: `PMICS_ZERO,
                   sns_s0: `PMICS_ZERO, sns_s1: `PMICS_ZERO, pin_s: 2'b00, rtc_s: 2'b00, irq: 1'b0};
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign irq_req = cur_reg.irq;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  AST_FLAG_SET: assert property (
    (evt_rise & ~force_bits) != `PMICS_ZERO |=>
      (cur_reg.flags & $past(evt_rise & ~force_bits)) == $past(evt_rise & ~force_bits))
    else $error("Flag did not set on its source rising.");

  AST_W1C: assert property (
    wr_flags |=> (cur_reg.flags & $past(reg_bus.wdata & ~evt_rise)) == `PMICS_ZERO)
    else $error("Written one did not clear the status flag.");

  AST_W0_KEEP: assert property (
    wr_flags && force_bits == `PMICS_ZERO |=>
      (cur_reg.flags & $past(~reg_bus.wdata & cur_reg.flags)) == $past(~reg_bus.wdata & cur_reg.flags))
    else $error("Written zero changed a status flag.");

  AST_PIN_HOLD: assert property (
    !cur_reg.pin_s[1] [*2] |-> (cur_reg.flags & `PMICS_PIN_BITS) == `PMICS_ZERO &&
      (cur_reg.masks & `PMICS_PIN_BITS) == `PMICS_PIN_BITS)
    else $error("Reset pin bits left default while pin low.");

  // A new event may still set an RTC flag while the pin is low, so only a lost flag is an error.
  AST_RTC_SURVIVE: assert property (
    !cur_reg.pin_s[1] && cur_reg.rtc_s[1] && off_entry_reset_n && !reg_bus.wr_p |=>
      (cur_reg.flags & $past(cur_reg.flags) & `PMICS_RTC_BITS) == ($past(cur_reg.flags) & `PMICS_RTC_BITS))
    else $error("RTC reset flags disturbed by reset pin.");

  AST_RTC_FORCE: assert property (
    !cur_reg.rtc_s[1] |=> (cur_reg.flags & `PMICS_RTC_BITS) == `PMICS_ZERO)
    else $error("RTC bits not forced while RTC reset low.");

  AST_OFF_FORCE: assert property (
    !off_entry_reset_n |=> (cur_reg.flags & `PMICS_OFF_BITS) == `PMICS_ZERO &&
      (cur_reg.masks & `PMICS_OFF_BITS) == `PMICS_OFF_BITS)
    else $error("Off-state bits not returned to default.");

  AST_RESERVED: assert property (
    (cur_reg.flags & ~`PMICS_IMPL_BITS) == `PMICS_ZERO && (cur_reg.masks | `PMICS_IMPL_BITS) == `PMICS_MASKS_RST)
    else $error("Reserved bit left its fixed value.");

  AST_IRQ: assert property (
    ##1 irq_req == $past(|(cur_reg.flags & ~cur_reg.masks)))
    else $error("Interrupt request does not follow unmasked flags.");

  AST_SENSE_LIVE: assert property (
    (sense_view & ~SENSE_LATCH_BITS) == ($past(src_sense_lvl, 2) & `PMICS_SENSE_BITS & ~SENSE_LATCH_BITS))
    else $error("Live sense bit is not the input level.");

  AST_LATCH_HOLD: assert property (
    !start_begin_p |=> cur_reg.latched == $past(cur_reg.latched))
    else $error("Latched sense changed outside startup.");

  AST_MODE_LOAD: assert property (
    start_begin_p && force_bits == `PMICS_ZERO |=>
      (cur_reg.masks & MASK_MODE_BITS) == ($past(mode_defaults) & MASK_MODE_BITS))
    else $error("Mode default not loaded at start.");

  CVR_FLAG_SET: cover property (evt_rise != `PMICS_ZERO ##1 cur_reg.flags != `PMICS_ZERO);
  CVR_IRQ: cover property (!irq_req ##1 irq_req);
  CVR_W1C: cover property (wr_flags && (cur_reg.flags & reg_bus.wdata) != `PMICS_ZERO);
  CVR_PIN_RESET: cover property (cur_reg.pin_s[1] ##1 !cur_reg.pin_s[1]);
endmodule

// ---- core/pmics_pkg.sv ----
// Types shared by the interrupt bookkeeping block.
package pmics_pkg;
  typedef logic [23:0] pmics_word_t;
  typedef logic [5:0] pmics_addr_t;

  typedef struct packed {
    pmics_word_t flags;
    pmics_word_t masks;
    pmics_word_t latched;
    pmics_word_t evt_s0;
    pmics_word_t evt_s1;
    pmics_word_t evt_s2;
    pmics_word_t sns_s0;
    pmics_word_t sns_s1;
    logic [1:0] pin_s;
    logic [1:0] rtc_s;
    logic irq;
  } pmics_state_t;

  typedef struct packed {
    logic [2:0] sclk_s;
    logic [1:0] cs_s;
    logic [1:0] mosi_s;
    logic [5:0] cnt;
    logic [31:0] shift_in;
    pmics_word_t shift_out;
    logic miso;
    logic miso_oe;
    logic wr_p;
    pmics_addr_t addr;
    pmics_word_t wdata;
  } pmics_spi_state_t;
endpackage

// ---- core/pmics_reg_if.sv ----
// Register access channel between the serial port engine and the register file.
`timescale 1ns/1ps
interface pmics_reg_if;
  import pmics_pkg::*;
  logic wr_p;
  pmics_addr_t addr;
  pmics_word_t wdata;
  pmics_word_t rdata;
  modport engine (output wr_p, output addr, output wdata, input rdata);
  modport regs (input wr_p, input addr, input wdata, output rdata);
endinterface

// ---- core/pmics_spi_port.sv ----
// Serial register port engine: frame decode, register read data and write strobe.
`timescale 1ns/1ps
module pmics_spi_port (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic spi_clk,
  input wire logic spi_cs_b,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  pmics_reg_if.engine bus
);
  import pmics_pkg::*;
  `include "pmics_defines.svh"

  pmics_spi_state_t cur_reg;
  pmics_spi_state_t cur_next;
  logic sclk_rise;
  logic sclk_fall;

  // Serial clock is oversampled, so it must run at most an eighth of mclk.
  assign sclk_rise = cur_reg.sclk_s[1] & ~cur_reg.sclk_s[2];
  assign sclk_fall = ~cur_reg.sclk_s[1] & cur_reg.sclk_s[2];

  always_comb begin
    cur_next = cur_reg;
    cur_next.sclk_s = {cur_reg.sclk_s[1:0], spi_clk};
    cur_next.cs_s = {cur_reg.cs_s[0], spi_cs_b};
    cur_next.mosi_s = {cur_reg.mosi_s[0], spi_mosi};
    cur_next.wr_p = 1'b0;
    if (cur_reg.cs_s[1]) begin
      cur_next.cnt = 6'h00;
      cur_next.miso = 1'b0;
      cur_next.miso_oe = 1'b0;
    end else begin
      cur_next.miso_oe = 1'b1;
      if (sclk_rise && cur_reg.cnt < `PMICS_FRAME_BITS) begin
        cur_next.shift_in = {cur_reg.shift_in[30:0], cur_reg.mosi_s[1]};
        cur_next.cnt = cur_reg.cnt + 6'h01;
        if (cur_reg.cnt + 6'h01 == `PMICS_ADDR_DONE) begin
          cur_next.addr = {cur_reg.shift_in[4:0], cur_reg.mosi_s[1]};
        end
        // Register index 0 to 63, 24 data bits after rw, index and one idle bit.
        if (cur_reg.cnt + 6'h01 == `PMICS_FRAME_BITS && cur_reg.shift_in[`PMICS_RW_POS - 1]) begin
          cur_next.wr_p = 1'b1;
          cur_next.wdata = {cur_reg.shift_in[22:0], cur_reg.mosi_s[1]};
        end
      end
      if (sclk_fall) begin
        if (cur_reg.cnt == `PMICS_DATA_START) begin
          cur_next.miso = bus.rdata[23];
          cur_next.shift_out = {bus.rdata[22:0], 1'b0};
        end else if (cur_reg.cnt > `PMICS_DATA_START) begin
          cur_next.miso = cur_reg.shift_out[23];
          cur_next.shift_out = {cur_reg.shift_out[22:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cur_reg <= '{sclk_s: 3'b000, cs_s: 2'b11, mosi_s: 2'b00, cnt: 6'h00, shift_in: 32'h0000_0000,
                   shift_out: 24'h00_0000, miso: 1'b0, miso_oe: 1'b0, wr_p: 1'b0, addr: 6'h00,
                   wdata: 24'h00_0000};
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign spi_miso = cur_reg.miso;
  assign spi_miso_oe = cur_reg.miso_oe;
  assign bus.wr_p = cur_reg.wr_p;
  assign bus.addr = cur_reg.addr;
  assign bus.wdata = cur_reg.wdata;
endmodule

// ---- sim/pmics_host_model.sv ----
// Host processor model that drives the serial register port in mode 0, one 32-bit frame per register access.
`timescale 1ns/1ps
module pmics_host_model (
  input wire logic mclk,
  output logic spi_clk,
  output logic spi_cs_b,
  output logic spi_mosi,
  input wire logic spi_miso
);
  import pmics_pkg::*;
  initial begin
    spi_clk = 1'b0;
    spi_cs_b = 1'b1;
    spi_mosi = 1'b1;
  end
  // Each clock phase lasts 8 mclk, twice the minimum, so the synchronisers in the port always see every edge.
  task automatic xfer(input logic rw, input pmics_addr_t idx, input pmics_word_t wd, output pmics_word_t rd);
    logic [31:0] frame;
    int i;
    frame = {rw, idx, 1'b0, wd};
    rd = 24'h00_0000;
    @(negedge mclk) spi_cs_b = 1'b0;
    for (i = 31; i >= 0; i--) begin
      @(negedge mclk) spi_mosi = frame[i];
      repeat (7) @(negedge mclk);
      spi_clk = 1'b1;
      if (i < 24) begin
        rd[i] = spi_miso;
      end
      repeat (8) @(negedge mclk);
      spi_clk = 1'b0;
    end
    repeat (8) @(negedge mclk);
    spi_cs_b = 1'b1;
    // The data line is not held once the frame ends, so show the inverse rather than a stale value.
    spi_mosi = ~spi_mosi;
    repeat (4) @(negedge mclk);
  endtask
endmodule

// ---- sim/tb_top.sv ----
// Self-checking testbench of the interrupt group 0 register file.
`timescale 1ns/1ps
module tb_top;
  import pmics_pkg::*;
  logic mclk;
  logic rst_b;
  logic system_reset_pin_n;
  logic rtc_power_on_reset_n;
  logic off_entry_reset_n;
  logic start_begin_p;
  pmics_word_t mode_defaults;
  pmics_word_t src_event_lvl;
  pmics_word_t src_sense_lvl;
  logic spi_clk;
  logic spi_cs_b;
  logic spi_mosi;
  logic spi_miso;
  logic spi_miso_oe;
  logic irq_req;
  int bad_count = 0;
  int n_compared = 0;
  pmics_irq_top #(.SENSE_LATCH_BITS(24'h00_0008), .SENSE_POWERUP(24'h00_0008), .MASK_MODE_BITS(24'h00_0004)) i_dut (
    .mclk(mclk), .rst_b(rst_b), .system_reset_pin_n(system_reset_pin_n),
    .rtc_power_on_reset_n(rtc_power_on_reset_n), .off_entry_reset_n(off_entry_reset_n),
    .start_begin_p(start_begin_p), .mode_defaults(mode_defaults), .src_event_lvl(src_event_lvl),
    .src_sense_lvl(src_sense_lvl), .spi_clk(spi_clk), .spi_cs_b(spi_cs_b), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .irq_req(irq_req));
  pmics_host_model i_host (.mclk(mclk), .spi_clk(spi_clk), .spi_cs_b(spi_cs_b), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic close_out();
    if (bad_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input pmics_word_t seen, input pmics_word_t exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input pmics_addr_t idx, input pmics_word_t d);
    pmics_word_t old;
    i_host.xfer(1'b1, idx, d, old);
  endtask
  task automatic chk_reg(input pmics_addr_t idx, input pmics_word_t exp);
    pmics_word_t v;
    i_host.xfer(1'b0, idx, 24'h00_0000, v);
    check(v, exp);
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic t_reset();
    chk_reg(6'h00, 24'h00_0000);
    chk_reg(6'h01, 24'hFF_FFFF);
    chk_reg(6'h02, 24'h00_0008);
    check({23'h0, irq_req}, 24'h00_0000);
    check({23'h0, spi_miso_oe}, 24'h00_0000);
  endtask
  task automatic t_start();
    start_begin_p = 1'b1;
    settle(1);
    start_begin_p = 1'b0;
    src_sense_lvl = 24'hFF_FFFF;
    settle(4);
    chk_reg(6'h02, 24'h19_7FF0);
    chk_reg(6'h01, 24'hFF_FFFB);
    wr(6'h01, 24'h00_0000);
    chk_reg(6'h01, 24'hC6_8000);
    // A second start with the mode pins high must load a one and latch the high sense level.
    mode_defaults = 24'hFF_FFFF;
    start_begin_p = 1'b1;
    settle(1);
    start_begin_p = 1'b0;
    mode_defaults = 24'h00_0000;
    src_sense_lvl = 24'h00_0300;
    settle(4);
    chk_reg(6'h01, 24'hC6_8004);
    chk_reg(6'h02, 24'h00_0308);
  endtask
  task automatic t_events();
    wr(6'h01, 24'h00_0000);
    chk_reg(6'h01, 24'hC6_8000);
    src_event_lvl = 24'hFF_FFFF;
    settle(10);
    chk_reg(6'h00, 24'h39_7FFF);
    check({23'h0, irq_req}, 24'h00_0001);
    wr(6'h00, 24'h00_0000);
    chk_reg(6'h00, 24'h39_7FFF);
    wr(6'h00, 24'h00_0001);
    chk_reg(6'h00, 24'h39_7FFE);
    wr(6'h01, 24'hFF_FFFF);
    settle(4);
    check({23'h0, irq_req}, 24'h00_0000);
  endtask
  task automatic t_refuse();
    wr(6'h02, 24'h00_0000);
    chk_reg(6'h02, 24'h00_0308);
    wr(6'h3F, 24'hFF_FFFF);
    chk_reg(6'h3F, 24'h00_0000);
  endtask
  task automatic t_groups();
    src_event_lvl = 24'h00_0000;
    wr(6'h01, 24'h00_0000);
    src_event_lvl = 24'hFF_FFFF;
    settle(10);
    system_reset_pin_n = 1'b0;
    settle(4);
    // Reads run while the pin is still low, so the force must hold over many hundred cycles.
    chk_reg(6'h00, 24'h01_10E8);
    chk_reg(6'h01, 24'hFE_EF17);
    system_reset_pin_n = 1'b1;
    settle(4);
    off_entry_reset_n = 1'b0;
    settle(2);
    off_entry_reset_n = 1'b1;
    settle(4);
    chk_reg(6'h00, 24'h00_00A0);
    chk_reg(6'h01, 24'hFF_FF5F);
    rtc_power_on_reset_n = 1'b0;
    settle(4);
    rtc_power_on_reset_n = 1'b1;
    settle(4);
    chk_reg(6'h00, 24'h00_0000);
    wr(6'h01, 24'h00_0000);
    chk_reg(6'h01, 24'hC6_8000);
    check({23'h0, irq_req}, 24'h00_0000);
  endtask
  initial begin
    rst_b = 1'b0;
    system_reset_pin_n = 1'b1;
    rtc_power_on_reset_n = 1'b1;
    off_entry_reset_n = 1'b1;
    start_begin_p = 1'b0;
    mode_defaults = 24'h00_0000;
    src_event_lvl = 24'h00_0000;
    src_sense_lvl = 24'h00_0000;
    settle(12);
    rst_b = 1'b1;
    settle(4);
    t_reset();
    t_start();
    t_events();
    t_refuse();
    t_groups();
    close_out();
  end
  // About 29 frames of some 525 cycles each are expected; the limit leaves ample margin.
  initial begin
    repeat (60000) @(posedge mclk);
    bad_count++;
    close_out();
  end
endmodule
